// file: nqm_pkg.sv
// Constants and carrier types shared by the queue-management command block.
package nqm_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAP = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_KILLED = 8'h0C;

  // Reset values: queuing enabled, every capability offered.
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [4:0] CAP_ABORT_RST = 5'h1F;
  localparam logic [2:0] CAP_DL_RST = 3'h7;

  // Field positions in the CAP register.
  localparam int CAP_ABORT_LSB = 0;
  localparam int CAP_DL_LSB = 8;

  // Command and subcommand encodings.
  localparam logic [7:0] CMD_QMGMT = 8'h63;
  localparam logic [3:0] SUB_ABORT = 4'h0;
  localparam logic [3:0] SUB_DEADLINE = 4'h1;

  // Abort type codes carried in features bits 7:4 of the abort subcommand.
  localparam logic [3:0] ABT_ALL = 4'h0;
  localparam logic [3:0] ABT_STREAM = 4'h1;
  localparam logic [3:0] ABT_NONSTREAM = 4'h2;
  localparam logic [3:0] ABT_SELECTED = 4'h3;

  // Bit positions of the deadline request bits in features of subcommand 1h.
  localparam int FEAT_WRITE_DEADLINE_NO_CONTINUE_BIT = 4;
  localparam int FEAT_READ_DEADLINE_NO_CONTINUE_BIT = 5;

  // Tag fields sit in bits 7:3 of count and of the low LBA byte.
  localparam int TAG_LSB = 3;

  // Capability log layout.
  localparam logic [15:0] LOG_VERSION = 16'h0001;
  localparam logic [6:0] LOG_DW_ABORT = 7'h00;
  localparam logic [6:0] LOG_DW_DEADLINE = 7'h01;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] features;
    logic [15:0] count;
    logic [7:0] lbaLow;
  } nqm_cmd_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic abrt;
    logic [31:0] act;
    logic [31:0] kill;
  } nqm_res_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } nqm_state_e;

endpackage

// file: nqm_queue_mgmt.sv
// Queue-management command interpreter with capability log and APB registers.
//
// What this block does
// - Command code 63h is the queue-management command, queued with no data phase.
// - With queuing disabled the command aborts with ERR and ABRT.
// - Subcommand 0h is abort, 1h deadline handling, 2h-Fh reserved.
// - An invalid subcommand aborts the command and all outstanding queued commands.
// - The low LBA byte carries the managed queue tag selecting the target.
// - Abort runs immediately, ahead of normal queue ordering.
// - Abort only touches commands accepted before this command was accepted.
// - A supported abort type reports success even when nothing was aborted.
// - Success sends completion bits for this command and every aborted one.
// - Disabled queuing, own tag, invalid tag or unsupported type all abort.
// - Subcommand 1h sets the write and read deadline no-continue bits.
// - Deadline bits survive soft reset and COMRESET, lost on power-up reset.
// - Supported deadline handling completes without error via completion bits.
// - Capability log 12h exists whenever the command is supported, flagged in identify.
// - The log is 512 bytes with version word 0001h.
// - Dword 0 holds abort capability flags in bits 4:0, rest zero.
// - Dword 1 holds deadline capability flags in bits 2:0, rest zero.
// - All reserved log fields and dwords beyond the second read zero.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
module nqm_queue_mgmt
  import nqm_pkg::*;
#(
  parameter int QDEPTH = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic softReset,
  input wire logic comReset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmdValid,
  output logic cmdReady,
  input nqm_cmd_s cmd,
  input wire logic [31:0] activeTags,
  input wire logic [31:0] streamTags,
  output nqm_res_s res,
  output logic write_deadline_no_continue,
  output logic read_deadline_no_continue,
  input wire logic logReq,
  input wire logic [6:0] logDword,
  output logic logValid,
  output logic [31:0] logData,
  output logic [15:0] logVersion,
  output logic idQmSupported
);

  function automatic logic [31:0] tagBit(input logic [4:0] t);
    tagBit = 32'h0000_0001 << t;
  endfunction

  // Register state.
  logic [31:0] ctrl;
  logic [4:0] capAbort;
  logic [2:0] capDl;
  logic [31:0] killedLast;
  logic lastErr;
  logic [31:0] next_ctrl;
  logic [4:0] next_capAbort;
  logic [2:0] next_capDl;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic apbAccess;
  logic apbSetup;
  logic mapped;
  logic queuingOn;

  assign apbAccess = psel && penable;
  assign apbSetup = psel && !penable;
  assign pready = 1'b1;
  assign queuingOn = ctrl[0];
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_CAP) || (paddr == OFF_STATUS) || (paddr == OFF_KILLED);

  always_comb begin
    next_ctrl = ctrl;
    next_capAbort = capAbort;
    next_capDl = capDl;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    // Read data and the error flag are registered in the setup cycle, so they already
    // stand in the access cycle in which the master takes them with no wait state.
    if (apbSetup) begin
      next_pslverr = !mapped;
      if (!pwrite) begin
        unique case (paddr)
          OFF_CTRL: next_prdata = ctrl;
          OFF_CAP: next_prdata = {21'h00_0000, capDl, 3'h0, capAbort};
          OFF_STATUS: next_prdata = {29'h0000_0000, lastErr, read_deadline_no_continue,
                                     write_deadline_no_continue};
          OFF_KILLED: next_prdata = killedLast;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (apbAccess && pwrite) begin
      if (paddr == OFF_CTRL) begin
        next_ctrl = {31'h0000_0000, pwdata[0]};
      end
      if (paddr == OFF_CAP) begin
        next_capAbort = pwdata[CAP_ABORT_LSB +: 5];
        next_capDl = pwdata[CAP_DL_LSB +: 3];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RST;
      capAbort <= CAP_ABORT_RST;
      capDl <= CAP_DL_RST;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      capAbort <= next_capAbort;
      capDl <= next_capDl;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Command execution. The snapshot of accepted tags is taken when this command is
  // accepted, so commands that arrive later can never be swept up by the abort.
  nqm_state_e state;
  nqm_state_e next_state;
  nqm_cmd_s held;
  nqm_cmd_s next_held;
  logic [31:0] snapTags;
  logic [31:0] next_snapTags;
  logic [31:0] snapStream;
  logic [31:0] next_snapStream;
  nqm_res_s next_res;
  logic [31:0] next_killedLast;
  logic next_lastErr;
  logic next_write_deadline_no_continue;
  logic next_read_deadline_no_continue;
  logic [4:0] ownTag;
  logic [4:0] tgtTag;
  logic [3:0] sub;
  logic [3:0] abType;
  logic tagBad;
  logic typeOk;
  logic wantW;
  logic wantR;
  logic [31:0] victims;
  logic localReset;

  assign localReset = softReset || comReset;
  assign cmdReady = (state == ST_IDLE);
  assign ownTag = held.count[TAG_LSB +: 5];
  assign tgtTag = held.lbaLow[TAG_LSB +: 5];
  assign sub = held.features[3:0];
  assign abType = held.features[7:4];
  assign wantW = held.features[FEAT_WRITE_DEADLINE_NO_CONTINUE_BIT];
  assign wantR = held.features[FEAT_READ_DEADLINE_NO_CONTINUE_BIT];
  assign tagBad = (tgtTag == ownTag) || (32'(tgtTag) >= QDEPTH);

  always_comb begin
    victims = 32'h0000_0000;
    typeOk = 1'b0;
    unique case (abType)
      ABT_ALL: begin
        typeOk = capAbort[1];
        victims = snapTags;
      end
      ABT_STREAM: begin
        typeOk = capAbort[2];
        victims = snapTags & snapStream;
      end
      ABT_NONSTREAM: begin
        typeOk = capAbort[3];
        victims = snapTags & ~snapStream;
      end
      ABT_SELECTED: begin
        typeOk = capAbort[4];
        victims = snapTags & tagBit(tgtTag);
      end
      default: begin
        typeOk = 1'b0;
        victims = 32'h0000_0000;
      end
    endcase
    victims = victims & ~tagBit(ownTag);
  end

  always_comb begin
    next_state = state;
    next_held = held;
    next_snapTags = snapTags;
    next_snapStream = snapStream;
    next_res = '0;
    next_killedLast = killedLast;
    next_lastErr = lastErr;
    next_write_deadline_no_continue = write_deadline_no_continue;
    next_read_deadline_no_continue = read_deadline_no_continue;
    unique case (state)
      ST_IDLE: begin
        if (cmdValid && cmd.code == CMD_QMGMT) begin
          next_held = cmd;
          next_snapTags = activeTags;
          next_snapStream = streamTags;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
        next_res.valid = 1'b1;
        next_res.err = 1'b1;
        next_res.abrt = 1'b1;
        if (!queuingOn) begin
          next_res.err = 1'b1;
        end else if (sub != SUB_ABORT && sub != SUB_DEADLINE) begin
          next_res.kill = snapTags;
        end else if (tagBad) begin
          next_res.err = 1'b1;
        end else if (sub == SUB_ABORT) begin
          if (capAbort[0] && typeOk) begin
            next_res.err = 1'b0;
            next_res.abrt = 1'b0;
            next_res.kill = victims;
            next_res.act = victims | tagBit(ownTag);
          end
        end else if (capDl[0] && (!wantW || capDl[1]) && (!wantR || capDl[2])) begin
          next_write_deadline_no_continue = wantW;
          next_read_deadline_no_continue = wantR;
          next_res.err = 1'b0;
          next_res.abrt = 1'b0;
          next_res.act = tagBit(ownTag);
        end
        next_killedLast = next_res.kill;
        next_lastErr = next_res.err;
      end
      default: next_state = ST_IDLE;
    endcase
    if (localReset) begin
      next_state = ST_IDLE;
      next_res = '0;
      // A command cut short by reset leaves no trace in the deadline bits or status.
      next_write_deadline_no_continue = write_deadline_no_continue;
      next_read_deadline_no_continue = read_deadline_no_continue;
      next_killedLast = killedLast;
      next_lastErr = lastErr;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      held <= '0;
      snapTags <= 32'h0000_0000;
      snapStream <= 32'h0000_0000;
      res <= '0;
      killedLast <= 32'h0000_0000;
      lastErr <= 1'b0;
      write_deadline_no_continue <= 1'b0;
      read_deadline_no_continue <= 1'b0;
    end else begin
      state <= next_state;
      held <= next_held;
      snapTags <= next_snapTags;
      snapStream <= next_snapStream;
      res <= next_res;
      killedLast <= next_killedLast;
      lastErr <= next_lastErr;
      // Soft reset and COMRESET deliberately leave the deadline bits alone.
      write_deadline_no_continue <= next_write_deadline_no_continue;
      read_deadline_no_continue <= next_read_deadline_no_continue;
    end
  end

  // Capability log read port; flags come from the same CAP bits the decoder uses.
  logic [31:0] next_logData;
  logic next_logValid;
  logic [15:0] next_logVersion;
  logic next_idQmSupported;

  always_comb begin
    next_logValid = logReq;
    next_logData = logData;
    next_logVersion = LOG_VERSION;
    next_idQmSupported = capAbort[0] || capDl[0];
    if (logReq) begin
      unique case (logDword)
        LOG_DW_ABORT: next_logData = {27'h000_0000, capAbort};
        LOG_DW_DEADLINE: next_logData = {29'h0000_0000, capDl};
        default: next_logData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      logValid <= 1'b0;
      logData <= 32'h0000_0000;
      logVersion <= 16'h0000;
      idQmSupported <= 1'b0;
    end else begin
      logValid <= next_logValid;
      logData <= next_logData;
      logVersion <= next_logVersion;
      idQmSupported <= next_idQmSupported;
    end
  end

endmodule // nqm_queue_mgmt

// file: nqm_queue_mgmt_chk.sv
// Assertion checker bound to the queue-management command block.
`timescale 1ns/100ps
module nqm_queue_mgmt_chk
  import nqm_pkg::*;
#(
  parameter int QDEPTH = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic softReset,
  input wire logic comReset,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input nqm_cmd_s cmd,
  input nqm_res_s res,
  input wire logic write_deadline_no_continue,
  input wire logic read_deadline_no_continue,
  input wire logic logReq,
  input wire logic [6:0] logDword,
  input wire logic logValid,
  input wire logic [31:0] logData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic taken = cmdValid && cmdReady && cmd.code == CMD_QMGMT;
  wire logic anyRst = softReset || comReset;
  // A soft reset or COMRESET drops a command in flight, so the answer time only holds without either.
  chk_res_late: assert property (disable iff (!nrst || anyRst) taken |-> ##2 res.valid)
    else $error("answer not two cycles after take");
  chk_cmd_busy: assert property (disable iff (!nrst || anyRst) taken |=> !cmdReady)
    else $error("ready during execution");
  chk_res_pulse: assert property (res.valid |=> !res.valid)
    else $error("result longer than one cycle");
  chk_err_abrt: assert property (res.valid |-> res.err == res.abrt)
    else $error("error and abort flags differ");
  chk_err_act: assert property (res.valid && res.err |-> res.act == 32'h0)
    else $error("completion bits on an aborted command");
  chk_ok_act: assert property (res.valid && !res.err |-> (res.act & res.kill) == res.kill && res.act != 32'h0)
    else $error("aborted tags missing from completion bits");
  chk_dl_keep: assert property (anyRst |=> $stable(write_deadline_no_continue) && $stable(read_deadline_no_continue))
    else $error("deadline bits lost on soft reset");
  chk_log_ans: assert property (logReq |=> logValid)
    else $error("log dword not answered");
  chk_log_zero: assert property (logValid && $past(logDword) > 7'h1 |-> logData == 32'h0)
    else $error("reserved log dword not zero");
  chk_other_code: assert property (cmdValid && cmdReady && cmd.code != CMD_QMGMT |=> cmdReady)
    else $error("foreign command code taken");
  cov_ok: cover property (res.valid && !res.err);
  cov_err: cover property (res.valid && res.err);
  cov_log: cover property (logValid);
endmodule // nqm_queue_mgmt_chk

bind nqm_queue_mgmt nqm_queue_mgmt_chk #(.QDEPTH(QDEPTH)) u_chk (.clk, .nrst, .softReset, .comReset, .cmdValid,
  .cmdReady, .cmd, .res, .write_deadline_no_continue, .read_deadline_no_continue, .logReq, .logDword, .logValid,
  .logData);

// file: nqm_host.sv
// Host controller model that offers one queued command at a time.
`timescale 1ns/100ps
module nqm_host
  import nqm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input nqm_cmd_s nextCmd,
  input wire logic [31:0] nextAct,
  input wire logic [31:0] nextStr,
  input wire logic cmdReady,
  output logic cmdValid,
  output nqm_cmd_s cmd,
  output logic [31:0] activeTags,
  output logic [31:0] streamTags
);
  // Only a device without the PACKET feature set is ever addressed.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmdValid <= 1'h0;
      cmd <= '0;
      activeTags <= 32'h0;
      streamTags <= 32'h0;
    end else if (cmdValid && cmdReady) begin
      cmdValid <= 1'h0;
      // A released bus shows the inverse of its last value, never a stale copy.
      cmd <= ~cmd;
      // New arrivals after acceptance must not be touched by the abort.
      activeTags <= ~activeTags;
    end else if (go) begin
      cmdValid <= 1'h1;
      cmd <= nextCmd;
      activeTags <= nextAct;
      streamTags <= nextStr;
    end
  end
endmodule // nqm_host

// file: nqm_queue_mgmt_tb.sv
// Self-checking bench for the queue-management command block.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t value mismatch", $time); end end
module nqm_queue_mgmt_tb
  import nqm_pkg::*;
;
  localparam int QD = 16;
  logic clk = 1'h0, nrst = 1'h0, softReset = 1'h0, comReset = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic go = 1'h0, logReq = 1'h0, en = 1'h1, wd = 1'h0, rd = 1'h0, le = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [6:0] logDword = 7'h0;
  logic [31:0] pwdata = 32'h0, ha = 32'h0, hs = 32'h0, prdata, activeTags, streamTags, logData, kl = 32'h0;
  logic pready, pslverr, cmdValid, cmdReady, write_deadline_no_continue, read_deadline_no_continue;
  logic logValid, idQmSupported;
  logic [15:0] logVersion;
  logic [4:0] capA = 5'h1F;
  logic [2:0] capD = 3'h7;
  nqm_cmd_s cmd, hc = '0;
  nqm_res_s res;
  int seed = 32'h9D7E;
  int bad_count = 0;
  int n_checks = 0;
  nqm_queue_mgmt #(.QDEPTH(QD)) dut (.clk, .nrst, .softReset, .comReset, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .cmdValid, .cmdReady, .cmd, .activeTags, .streamTags, .res, .write_deadline_no_continue,
    .read_deadline_no_continue, .logReq, .logDword, .logValid, .logData, .logVersion, .idQmSupported);
  nqm_host host (.clk, .nrst, .go, .nextCmd(hc), .nextAct(ha), .nextStr(hs), .cmdReady, .cmdValid, .cmd, .activeTags,
    .streamTags);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic er);
    logic rdy;
    logic [31:0] dat;
    logic err;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // What stands at the falling edge is what the next rising edge samples.
    do begin
      @(negedge clk);
      rdy = pready;
      dat = prdata;
      err = pslverr;
      @(posedge clk);
    end while (rdy !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    if (!w) `CHK(dat, x)
    `CHK(err, er)
  endtask
  task automatic logrd(input logic [6:0] d, input logic [31:0] x);
    @(posedge clk);
    logReq <= 1'h1;
    logDword <= d;
    @(posedge clk);
    logReq <= 1'h0;
    @(negedge clk);
    `CHK(logValid, 1'h1)
    `CHK(logData, x)
  endtask
  task automatic cmdrun(input logic [7:0] code, input logic [3:0] sub, input logic [3:0] typ);
    logic [4:0] tg;
    logic [4:0] tt;
    logic [31:0] a;
    logic [31:0] s;
    logic [31:0] k;
    logic e;
    tg = 5'($random(seed)) | 5'h10;
    tt = typ == 4'h5 ? tg : {typ == 4'h4, 4'($random(seed))};
    a = $random(seed);
    s = $random(seed);
    k = 32'h0;
    e = !en || sub > 4'h1 || tt == tg || tt >= QD;
    if (en && sub > 4'h1) begin
      k = a;
    end else if (!e && sub == SUB_ABORT) begin
      e = !capA[0] || typ > 4'h3 || !capA[typ + 1];
      if (!e) begin
        k = (typ == ABT_ALL ? a : typ == ABT_STREAM ? a & s : typ == ABT_NONSTREAM ? a & ~s : a & (32'h1 << tt));
        k = k & ~(32'h1 << tg);
      end
    end else if (!e) begin
      e = !capD[0] || (typ[0] && !capD[1]) || (typ[1] && !capD[2]);
      wd = e ? wd : typ[0];
      rd = e ? rd : typ[1];
    end
    @(posedge clk);
    hc <= '{code, {8'h0, typ, sub}, {8'h0, tg, 3'h0}, {tt, 3'h0}};
    ha <= a;
    hs <= s;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (6) begin
      @(negedge clk);
      if (res.valid === 1'h1) break;
    end
    `CHK(res.valid, code == CMD_QMGMT)
    if (code == CMD_QMGMT) begin
      `CHK(res.err, e)
      `CHK(res.abrt, e)
      `CHK(res.act, e ? 32'h0 : k | (32'h1 << tg))
      `CHK(res.kill, k)
      le = e;
      kl = k;
    end
    @(negedge clk);
    `CHK(write_deadline_no_continue, wd)
    `CHK(read_deadline_no_continue, rd)
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    apb(1'h0, OFF_CTRL, 32'h0, CTRL_RST, 1'h0);
    apb(1'h0, OFF_CAP, 32'h0, 32'h0000071F, 1'h0);
    apb(1'h0, 8'h10, 32'h0, 32'h0, 1'h1);
    `CHK(logVersion, LOG_VERSION)
    `CHK(idQmSupported, 1'h1)
    for (int p = 0; p < 3; p++) begin
      if (p > 0) begin
        capA = p == 1 ? 5'($random(seed)) : 5'h1F;
        capD = p == 1 ? 3'($random(seed)) : 3'h7;
        en = p == 1;
        apb(1'h1, OFF_CTRL, {31'h0, en}, 32'h0, 1'h0);
        apb(1'h1, OFF_CAP, {21'h0, capD, 3'h0, capA}, 32'h0, 1'h0);
      end
      for (int d = 0; d < 4; d++) begin
        logrd(7'(d), d == 0 ? {27'h0, capA} : d == 1 ? {29'h0, capD} : 32'h0);
      end
      `CHK(idQmSupported, capA[0] || capD[0])
      for (int s = 0; s < 6; s++) begin
        for (int t = 0; t < 6; t++) begin
          cmdrun(CMD_QMGMT, 4'(s), 4'(t));
        end
      end
      apb(1'h0, OFF_STATUS, 32'h0, {29'h0, le, rd, wd}, 1'h0);
      apb(1'h0, OFF_KILLED, 32'h0, kl, 1'h0);
    end
    cmdrun(8'h25, SUB_ABORT, ABT_ALL);
    logrd(7'h7F, 32'h0);
    apb(1'h1, OFF_CTRL, 32'h1, 32'h0, 1'h0);
    en = 1'h1;
    cmdrun(CMD_QMGMT, SUB_DEADLINE, 4'h3);
    @(posedge clk);
    softReset <= 1'h1;
    @(posedge clk);
    softReset <= 1'h0;
    comReset <= 1'h1;
    @(posedge clk);
    comReset <= 1'h0;
    @(negedge clk);
    `CHK(write_deadline_no_continue, wd)
    `CHK(read_deadline_no_continue, rd)
    @(posedge clk);
    nrst <= 1'h0;
    @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    `CHK(write_deadline_no_continue, 1'h0)
    `CHK(read_deadline_no_continue, 1'h0)
    results;
  end
endmodule // nqm_queue_mgmt_tb
